//--- logic/acsl_pkg.sv
// shared constants and types of the converter control and status logic
package acsl_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          APB_AW    = 12;
  localparam int          APB_DW    = 32;
  localparam int          CSR_W     = 8;
  localparam logic [11:0] CSR_ADDR  = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_BIT       = 7;
  localparam int IE_BIT         = 6;
  localparam int START_BIT      = 5;
  localparam int SCAN_BIT       = 4;
  localparam int TSEL_BIT       = 3;
  localparam int CHAN_LSB       = 0;
  localparam int CHAN_W         = 3;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_CHAN_LSB  = 1;
  localparam int STAT_STATE_LSB = 4;

  localparam logic [CSR_W-1:0]  CSR_RESET   = 8'h00;
  localparam logic [APB_DW-1:0] RDATA_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // conversion timing
  // ---------------------------------------------------------------
  localparam int STATES_SLOW      = 266;
  localparam int STATES_FAST      = 134;
  localparam int CYCLES_PER_STATE = 1;
  // start and end cycles of the sequencer are part of each conversion
  localparam int CONV_OVERHEAD    = 2;
  localparam int CONV_CYCLES_SLOW = STATES_SLOW * CYCLES_PER_STATE;
  localparam int CONV_CYCLES_FAST = STATES_FAST * CYCLES_PER_STATE;
  localparam int TMR_W            = 9;
  localparam logic [TMR_W-1:0] LOAD_SLOW = TMR_W'(CONV_CYCLES_SLOW - CONV_OVERHEAD - 1);
  localparam logic [TMR_W-1:0] LOAD_FAST = TMR_W'(CONV_CYCLES_FAST - CONV_OVERHEAD - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO  = 9'h000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [CHAN_W-1:0] acsl_chan_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_START   = 2'b01,
    ST_CONVERT = 2'b10,
    ST_END     = 2'b11
  } acsl_state_e;

  // commands to the analog conversion core
  typedef struct packed {
    logic       start;
    logic       finish;
    logic       fast;
    acsl_chan_t channel;
  } acsl_core_s;

  // result read notice from the transfer controller
  typedef struct packed {
    logic result_read;
    logic by_end_irq;
  } acsl_xfer_s;

  // power management requests
  typedef struct packed {
    logic standby;
    logic module_stop;
  } acsl_power_s;

  localparam acsl_core_s CORE_RESET = '{start: 1'b0, finish: 1'b0, fast: 1'b0,
                                        channel: 3'h0};

endpackage : acsl_pkg

//--- logic/acsl_conv_timer.sv
// conversion time counter, one for all channels, reloaded at the start of each conversion
`timescale 1ns/1ps
module acsl_conv_timer (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // control
  input  wire logic load,
  input  wire logic abort,
  input  wire logic fast,
  // status
  output logic      expired
);
  import acsl_pkg::*;

  logic [TMR_W-1:0] cnt_q;
  logic             run_q;

  // -------------------------------------------------------------
  // down counter
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= TMR_ZERO;
      run_q <= 1'b0;
    end else if (clk_en) begin
      if (abort) begin
        run_q <= 1'b0;
        cnt_q <= TMR_ZERO;
      end else if (load) begin
        run_q <= 1'b1;
        cnt_q <= fast ? LOAD_FAST : LOAD_SLOW;
      end else if (run_q) begin
        if (cnt_q == TMR_ZERO) begin
          run_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 9'h001;
        end
      end
    end
  end

  // last cycle of the conversion window
  assign expired = run_q && (cnt_q == TMR_ZERO);

endmodule : acsl_conv_timer

//--- logic/acsl_ctrl.sv
// converter control and status register with conversion sequencer
//
// Summary of operation
// - single mode sets end flag when the selected channel finishes converting.
// - scan mode sets end flag when the last channel of the group finishes.
// - end flag clears on zero write only after software read it as one.
// - transfer controller result read, started by end interrupt, clears end flag.
// - end interrupt is requested from the flag only while enable is one.
// - writing start one begins conversion; writing zero stops it at once.
// - single mode clears start bit by itself when its channel finishes.
// - scan repeats the group until software, reset, standby or stop clears start.
// - mode bit zero selects single conversion, one selects scan conversion.
// - time select zero gives 266 states per conversion, one gives 134.
// - writing one to the end flag has no effect.
`timescale 1ns/1ps
module acsl_ctrl (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [acsl_pkg::APB_AW-1:0] paddr,
  input  wire logic [acsl_pkg::APB_DW-1:0] pwdata,
  output logic                          pready,
  output logic [acsl_pkg::APB_DW-1:0]   prdata,
  output logic                          pslverr,
  // transfer controller and power management
  input  wire acsl_pkg::acsl_xfer_s     xfer,
  input  wire acsl_pkg::acsl_power_s    power,
  // analog conversion core
  output acsl_pkg::acsl_core_s          core,
  // interrupt request
  output logic                          conversion_end_interrupt
);
  import acsl_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                 conversion_end_flag_q;
  logic                 end_interrupt_enable_q;
  logic                 conversion_start_q;
  logic                 scan_mode_q;
  logic                 conversion_time_select_q;
  acsl_chan_t           chan_sel_q;
  logic                 flag_armed_q;
  logic                 sampled_q;
  logic [APB_DW-1:0]    prdata_q;
  logic                 pslverr_q;
  acsl_state_e          state_q;
  acsl_state_e          state_d;
  acsl_chan_t           chan_q;
  acsl_chan_t           chan_d;
  acsl_core_s           core_q;
  logic [CSR_W-1:0]     csr_value;
  logic [APB_DW-1:0]    rd_mux;
  logic                 rd_err;
  logic                 access_done;
  logic                 csr_hit;
  logic                 csr_write;
  logic                 csr_read;
  logic                 power_stop;
  logic                 sw_stop;
  logic                 timer_load;
  logic                 timer_abort;
  logic                 timer_expired;
  logic                 conv_end;
  logic                 last_chan;
  logic                 flag_set;
  logic                 flag_clear;
  acsl_chan_t           first_chan;

  // ---------------------------------------------------------------
  // apb access decode
  // ---------------------------------------------------------------
  assign pready      = clk_en && sampled_q;
  assign access_done = psel && penable && pready;
  assign csr_hit     = (paddr == CSR_ADDR);
  assign csr_write   = access_done && pwrite && csr_hit;
  assign csr_read    = access_done && !pwrite && csr_hit;
  assign prdata      = prdata_q;
  assign pslverr     = pslverr_q;

  // setup phase seen on an enabled edge; access completes one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_q <= 1'b0;
    end else if (clk_en) begin
      sampled_q <= psel && !access_done;
    end
  end

  // ---------------------------------------------------------------
  // read data mux
  // ---------------------------------------------------------------
  always_comb begin
    csr_value                 = CSR_RESET;
    csr_value[FLAG_BIT]       = conversion_end_flag_q;
    csr_value[IE_BIT]         = end_interrupt_enable_q;
    csr_value[START_BIT]      = conversion_start_q;
    csr_value[SCAN_BIT]       = scan_mode_q;
    csr_value[TSEL_BIT]       = conversion_time_select_q;
    csr_value[CHAN_LSB +: CHAN_W] = chan_sel_q;
  end

  always_comb begin
    rd_mux = RDATA_RESET;
    rd_err = 1'b0;
    if (paddr == CSR_ADDR) begin
      rd_mux[CSR_W-1:0] = csr_value;
    end else if (paddr == STAT_ADDR) begin
      rd_mux[STAT_BUSY_BIT]             = (state_q != ST_IDLE);
      rd_mux[STAT_CHAN_LSB +: CHAN_W]   = chan_q;
      rd_mux[STAT_STATE_LSB +: 2]       = state_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // data and error are registered while the transfer is selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= RDATA_RESET;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      if (psel && !access_done) begin
        prdata_q  <= pwrite ? RDATA_RESET : rd_mux;
        pslverr_q <= rd_err;
      end else if (access_done) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  // mode and time select are taken as written; software keeps them
  // steady while start is one, the sequencer relies on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_interrupt_enable_q   <= 1'b0;
      scan_mode_q              <= 1'b0;
      conversion_time_select_q <= 1'b0;
      chan_sel_q               <= 3'h0;
    end else if (clk_en) begin
      if (csr_write) begin
        end_interrupt_enable_q   <= pwdata[IE_BIT];
        scan_mode_q              <= pwdata[SCAN_BIT];
        conversion_time_select_q <= pwdata[TSEL_BIT];
        chan_sel_q               <= pwdata[CHAN_LSB +: CHAN_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // start bit
  // ---------------------------------------------------------------
  assign power_stop = power.standby || power.module_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_start_q <= 1'b0;
    end else if (clk_en) begin
      if (power_stop) begin
        conversion_start_q <= 1'b0;
      end else if (csr_write) begin
        conversion_start_q <= pwdata[START_BIT];
      end else if (conv_end && !scan_mode_q) begin
        conversion_start_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // end flag
  // ---------------------------------------------------------------
  assign last_chan  = (chan_q == chan_sel_q);
  assign flag_set   = conv_end && (!scan_mode_q || last_chan);
  // a zero write clears only after a read showed one; a transfer read by end interrupt also clears
  assign flag_clear = (csr_write && !pwdata[FLAG_BIT] && flag_armed_q)
                   || (xfer.result_read && xfer.by_end_irq);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_end_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (flag_set) begin
        conversion_end_flag_q <= 1'b1;
      end else if (flag_clear) begin
        conversion_end_flag_q <= 1'b0;
      end
    end
  end

  // remembers that software has seen the flag at one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_armed_q <= 1'b0;
    end else if (clk_en) begin
      if (csr_read) begin
        flag_armed_q <= prdata_q[FLAG_BIT];
      end else if (csr_write || !conversion_end_flag_q) begin
        flag_armed_q <= 1'b0;
      end
    end
  end

  assign conversion_end_interrupt = conversion_end_flag_q && end_interrupt_enable_q;

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  // scan group runs from the first channel of its half up to the selection
  assign first_chan = scan_mode_q ? {chan_sel_q[CHAN_W-1], 2'b00} : chan_sel_q;
  assign sw_stop    = !conversion_start_q;
  assign conv_end   = (state_q == ST_END) && !sw_stop;

  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    case (state_q)
      ST_IDLE: begin
        if (conversion_start_q) begin
          state_d = ST_START;
          chan_d  = first_chan;
        end
      end
      ST_START: begin
        state_d = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (timer_expired) begin
          state_d = ST_END;
        end
      end
      ST_END: begin
        if (!scan_mode_q) begin
          state_d = ST_IDLE;
        end else if (last_chan) begin
          state_d = ST_START;
          chan_d  = first_chan;
        end else begin
          state_d = ST_START;
          chan_d  = chan_q + 3'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (sw_stop) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      chan_q  <= 3'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      chan_q  <= chan_d;
    end
  end

  // ---------------------------------------------------------------
  // conversion core commands
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_q <= CORE_RESET;
    end else if (clk_en) begin
      core_q.start   <= (state_d == ST_START);
      core_q.finish  <= (state_d == ST_END);
      core_q.fast    <= conversion_time_select_q;
      core_q.channel <= chan_d;
    end
  end

  assign core = core_q;

  // ---------------------------------------------------------------
  // conversion time
  // ---------------------------------------------------------------
  assign timer_load  = (state_q == ST_START) && !sw_stop;
  assign timer_abort = sw_stop;

  acsl_conv_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .load    (timer_load),
    .abort   (timer_abort),
    .fast    (conversion_time_select_q),
    .expired (timer_expired)
  );

endmodule : acsl_ctrl

//--- tb/acsl_xfer_model.sv
// transfer controller model answering the conversion end interrupt
`timescale 1ns/1ps
module acsl_xfer_model (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // bench control and device request
  input  wire logic            enable,
  input  wire logic            by_irq,
  input  wire logic            irq,
  // result read notice
  output acsl_pkg::acsl_xfer_s xfer
);
  import acsl_pkg::*;
  logic       irq_q;
  logic       busy_q;
  logic [1:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q  <= 1'h0;
      busy_q <= 1'h0;
      cnt_q  <= 2'h0;
      xfer   <= '0;
    end else begin
      irq_q <= irq;
      if (enable && irq && !irq_q) begin
        busy_q <= 1'h1;
        cnt_q  <= 2'h3;
        xfer   <= '{result_read: 1'h0, by_end_irq: !xfer.by_end_irq};
      end else if (busy_q && cnt_q == 2'h0) begin
        busy_q <= 1'h0;
        xfer   <= '{result_read: 1'h1, by_end_irq: by_irq};
      end else begin
        // qualifier toggles while no read is reported
        xfer <= '{result_read: 1'h0, by_end_irq: !xfer.by_end_irq};
        if (busy_q) begin
          cnt_q <= cnt_q - 2'h1;
        end
      end
    end
  end
endmodule : acsl_xfer_model

//--- tb/acsl_ctrl_assertions.sv
// concurrent checks on the ports of the converter control logic
`timescale 1ns/1ps
module acsl_ctrl_assertions (
  // clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        clk_en,
  // apb
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [acsl_pkg::APB_AW-1:0] paddr,
  input wire logic [acsl_pkg::APB_DW-1:0] pwdata,
  input wire logic                        pready,
  input wire logic [acsl_pkg::APB_DW-1:0] prdata,
  input wire logic                        pslverr,
  // side ports
  input wire acsl_pkg::acsl_xfer_s        xfer,
  input wire acsl_pkg::acsl_power_s       power,
  input wire acsl_pkg::acsl_core_s        core,
  input wire logic                        conversion_end_interrupt
);
  import acsl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       csr_wr;
  logic       halt;
  logic       stop_evt;
  logic       start_evt;
  logic       run_q;
  logic [3:0] quiet_q;
  assign csr_wr    = psel && penable && pready && pwrite && paddr == CSR_ADDR;
  assign halt      = (power.standby || power.module_stop) && clk_en;
  assign stop_evt  = (csr_wr && !pwdata[START_BIT]) || halt;
  assign start_evt = csr_wr && pwdata[START_BIT] && !halt;
  // enabled cycles after a stop in which the core must stay silent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 4'h0;
    end else if (start_evt) begin
      quiet_q <= 4'h0;
    end else if (stop_evt) begin
      quiet_q <= 4'h9;
    end else if (clk_en && quiet_q != 4'h0) begin
      quiet_q <= quiet_q - 4'h1;
    end
  end
  // a conversion is under way between core start and finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (stop_evt || quiet_q != 4'h0) begin
      run_q <= 1'b0;
    end else if (core.start) begin
      run_q <= 1'b1;
    end else if (core.finish) begin
      run_q <= 1'b0;
    end
  end
  AST_START_ON_WRITE: assert property (
    start_evt && !run_q && !core.start ##1 clk_en |=> core.start)
    else $error("start write gave no core start");
  AST_STOP_ON_WRITE: assert property (
    quiet_q != 4'h0 && quiet_q != 4'h9 |-> !core.start && !core.finish)
    else $error("conversion ran on after stop write");
  AST_POWER_STOP: assert property (
    halt ##1 clk_en |=> !core.start && !core.finish)
    else $error("conversion ran on in standby or stop");
  AST_FAST_TIME: assert property (core.finish && core.fast |-> $past(core.start, 133))
    else $error("fast conversion length wrong");
  AST_SLOW_TIME: assert property (core.finish && !core.fast |-> $past(core.start, 265))
    else $error("slow conversion length wrong");
  AST_IRQ_HOLD: assert property (conversion_end_interrupt && !csr_wr && !xfer.result_read |=> conversion_end_interrupt)
    else $error("interrupt dropped without clear");
  AST_IRQ_RISE: assert property ($rose(conversion_end_interrupt) |-> $past(core.finish) || $past(csr_wr && pwdata[IE_BIT]))
    else $error("interrupt rose without cause");
  AST_XFER_CLEAR: assert property (
    xfer.result_read && xfer.by_end_irq && !core.finish && clk_en |=> !conversion_end_interrupt)
    else $error("transfer read left interrupt set");
  AST_READY: assert property (psel && !penable && clk_en ##1 clk_en |-> pready)
    else $error("no ready after setup");
  AST_UNMAPPED: assert property (psel && penable && pready && paddr != CSR_ADDR && paddr != STAT_ADDR |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  COV_FAST: cover property (core.finish && core.fast);
  COV_STOP: cover property (csr_wr && !pwdata[START_BIT]);
  COV_IRQ: cover property ($rose(conversion_end_interrupt));
  COV_ERR: cover property (pslverr);
endmodule : acsl_ctrl_assertions

bind acsl_ctrl acsl_ctrl_assertions i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .xfer(xfer), .power(power),
  .core(core), .conversion_end_interrupt(conversion_end_interrupt));

//--- tb/tb_top.sv
// self-checking testbench of the converter control logic
`timescale 1ns/1ps
module tb_top;
  import acsl_pkg::*;
  logic              pclk    = 1'h0;
  logic              presetn = 1'h0;
  logic              clk_en  = 1'h1;
  logic              psel    = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite  = 1'h0;
  logic [APB_AW-1:0] paddr   = 12'h000;
  logic [APB_DW-1:0] pwdata  = 32'h0000_0000;
  logic              pready;
  logic [APB_DW-1:0] prdata;
  logic              pslverr;
  acsl_xfer_s        xfer;
  acsl_power_s       power   = '0;
  acsl_core_s        core;
  logic              irq;
  logic              xm_by   = 1'h0;
  logic [APB_DW-1:0] rd;
  logic              er;
  acsl_chan_t        chq[$];
  int                fail_count = 0;
  int                checked    = 0;
  int                cyc = 0;
  int                st_cyc = 0;
  int                fin_cyc = 0;
  int                nfin = 0;

  acsl_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .xfer(xfer), .power(power), .core(core),
    .conversion_end_interrupt(irq));
  acsl_xfer_model i_xm (.pclk(pclk), .presetn(presetn), .enable(1'h1), .by_irq(xm_by),
    .irq(irq), .xfer(xfer));

  initial begin
    forever #5 pclk = ~pclk;
  end
  // core command monitor
  always @(negedge pclk) begin
    cyc++;
    if (core.start === 1'h1) begin
      st_cyc = cyc;
      chq.push_back(core.channel);
    end
    if (core.finish === 1'h1) begin
      fin_cyc = cyc;
      nfin++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    chk(irq, exp);
  endtask : chk_irq
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(negedge pclk);
    while (pready !== 1'h1) @(negedge pclk);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rd_chk
  task automatic wait_fin();
    int n;
    n = nfin;
    while (nfin == n) @(negedge pclk);
  endtask : wait_fin
  task automatic idle_chk();
    int n;
    n = nfin;
    repeat (300) @(negedge pclk);
    chk(nfin, n);
  endtask : idle_chk

  task automatic t_reset();
    rd_chk(CSR_ADDR, 32'(CSR_RESET));
    rd_chk(STAT_ADDR, 32'h0000_0000);
    chk_irq(1'h0);
  endtask : t_reset
  task automatic t_single(input logic f);
    chq.delete();
    wr(CSR_ADDR, 32'h0000_0065 | (32'(f) << TSEL_BIT));
    wait_fin();
    chk(fin_cyc - st_cyc, (f ? STATES_FAST : STATES_SLOW) - 1);
    chk(core.fast, f);
    chk(chq[0], 5);
    repeat (8) @(negedge pclk);
    chk(irq, 1'h1);
    rd_chk(CSR_ADDR, 32'h0000_00C5 | (32'(f) << TSEL_BIT));
    chk(chq.size(), 1);
  endtask : t_single
  task automatic t_clear();
    wr(CSR_ADDR, 32'h0000_00C0);
    wr(CSR_ADDR, 32'h0000_0040);
    rd_chk(CSR_ADDR, 32'h0000_00C0);
    wr(CSR_ADDR, 32'h0000_0040);
    rd_chk(CSR_ADDR, 32'h0000_0040);
    chk_irq(1'h0);
  endtask : t_clear
  task automatic t_mask();
    wr(CSR_ADDR, 32'h0000_002D);
    wait_fin();
    repeat (2) @(negedge pclk);
    chk(irq, 1'h0);
    wr(CSR_ADDR, 32'h0000_00C8);
    chk_irq(1'h1);
    rd_chk(CSR_ADDR, 32'h0000_00C8);
    wr(CSR_ADDR, 32'h0000_0048);
    chk_irq(1'h0);
  endtask : t_mask
  task automatic t_scan();
    xm_by = 1'h1;
    chq.delete();
    wr(CSR_ADDR, 32'h0000_007E);
    for (int k = 0; k < 4; k++) begin
      wait_fin();
      chk_irq(k == 2);
      chk(chq[k], 4 + k % 3);
    end
    wr(CSR_ADDR, 32'h0000_005E);
    idle_chk();
    rd_chk(CSR_ADDR, 32'h0000_005E);
  endtask : t_scan
  task automatic t_stop();
    for (int k = 0; k < 2; k++) begin
      wr(CSR_ADDR, 32'h0000_0023);
      repeat (20) @(posedge pclk);
      rd_chk(STAT_ADDR, 32'h0000_0027);
      power <= acsl_power_s'(2'(k + 1));
      @(posedge pclk);
      power <= '0;
      idle_chk();
      rd_chk(CSR_ADDR, 32'h0000_0003);
    end
  endtask : t_stop
  task automatic t_apb();
    fork
      begin
        repeat (2) @(posedge pclk);
        clk_en <= 1'h0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'h1;
      end
    join_none
    rd_chk(12'h008, 32'h0000_0000);
    chk(er, 1'h1);
  endtask : t_apb

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    for (int f = 1; f >= 0; f--) t_single(f[0]);
    t_clear();
    t_mask();
    t_scan();
    t_stop();
    t_apb();
    give_verdict();
  end
endmodule : tb_top
